/* File: core/nfh_defs.vh */
/*
  constants for the nand flash host sequencer: command codes, cycle counts.
  assumes a 125 MHz system clock (8 ns period).
*/
`ifndef NFH_DEFS_VH
`define NFH_DEFS_VH

`define NFH_CLK_NS            8
// command codes
`define NFH_CMD_READ1         8'h00
`define NFH_CMD_READ2         8'h30
`define NFH_CMD_CACHE_RD      8'h31
`define NFH_CMD_CACHE_RD_END  8'h3F
`define NFH_CMD_COPY          8'h3A
`define NFH_CMD_PROG1         8'h80
`define NFH_CMD_PROG2         8'h10
`define NFH_CMD_CACHE_PROG    8'h15
`define NFH_CMD_PROG_CONT     8'h11
`define NFH_CMD_ERASE1        8'h60
`define NFH_CMD_ERASE2        8'hD0
`define NFH_CMD_STATUS        8'h70
`define NFH_CMD_RESET         8'hFF
// op kinds on the user port
`define NFH_OP_CMD            3'h0
`define NFH_OP_ADDR           3'h1
`define NFH_OP_WDATA          3'h2
`define NFH_OP_RDATA          3'h3
`define NFH_OP_WAIT           3'h4
// wait classes, select the timeout limit
`define NFH_WC_FETCH          3'h0
`define NFH_WC_CACHE_RD       3'h1
`define NFH_WC_COPY           3'h2
`define NFH_WC_RESET          3'h3
`define NFH_WC_CPROG_SHORT    3'h4
`define NFH_WC_CPROG_LONG     3'h5
`define NFH_WC_PROG_LAST      3'h6
// times in ns
`define NFH_ADDR_DATA_GAP_NS  80
`define NFH_READY_GAP_NS      20
`define NFH_HOLD_RISE_NS      30
`define NFH_STROBE_LOW_NS     20
`define NFH_STROBE_HIGH_NS    12
// times in us
`define NFH_FETCH_US          250
`define NFH_CACHE_RD_US       250
`define NFH_COPY_US           260
`define NFH_RESET_US          500
`define NFH_CPROG_SHORT_US    10
`define NFH_CPROG_LONG_US     10000
`define NFH_PROG_MAX_US       6000
// cycle counts, least times rounded up
`define NFH_CYC_MIN(ns)       (((ns) + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_CYC_US(us)        (((us) * 1000) / `NFH_CLK_NS)
// the same counts sized to their counters, except the last-program limit at twice NFH_PROG_MAX_US, so nothing is cut silently
`define NFH_CYC_LOW           4'h3
`define NFH_CYC_HIGH          4'h2
`define NFH_CYC_HOLD          4'h4
`define NFH_CYC_AGAP          4'hA
`define NFH_CYC_RGAP          4'h3
`define NFH_TO_FETCH          24'h007A12
`define NFH_TO_CACHE_RD       24'h007A12
`define NFH_TO_COPY           24'h007EF4
`define NFH_TO_RESET          24'h00F424
`define NFH_TO_CPROG_SHORT    24'h0004E2
`define NFH_TO_CPROG_LONG     24'h1312D0
`define NFH_TO_PROG_LAST      24'h16E360
`endif

/* File: core/nfh_buf2.v */
/*
  two-entry buffer with valid/ready on both sides.
  assumes one clock, asynchronous active-high reset.
*/
module nfh_buf2 (
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire       i_valid,
  output wire       o_ready,
  input  wire [7:0] i_data,
  output wire       o_valid,
  input  wire       i_ready,
  output wire [7:0] o_data
);
  reg [7:0] mem [0:1];
  reg       wr_ptr;
  reg       rd_ptr;
  reg [1:0] count;
  wire      push;
  wire      pop;

  assign o_ready = (count != 2'h2);
  assign o_valid = (count != 2'h0);
  assign o_data  = mem[rd_ptr];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
      mem[0] <= 8'h00;
      mem[1] <= 8'h00;
    end else begin
      if (push) begin
        mem[wr_ptr] <= i_data;
        wr_ptr      <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push & ~pop)
        count <= count + 2'h1;
      else if (pop & ~push)
        count <= count - 2'h1;
    end
  end
endmodule

/* File: core/nfh_host.v */
/*
  host-side nand flash sequencer: drives command, address, write and read
  cycles on the flash pins and waits out busy periods with timeouts.
  assumes flash pins are synchronous to I_SYS_CLK; the bus pad and the
  ready/busy pull-up are outside.
*/
`include "nfh_defs.vh"
module nfh_host (
  input  wire       I_SYS_CLK,
  input  wire       I_SYS_RST,
  input  wire       i_op_valid,
  output wire       o_op_ready,
  input  wire [2:0] i_op_kind,
  input  wire [7:0] i_op_data,
  output wire       o_rd_valid,
  input  wire       i_rd_ready,
  output wire [7:0] o_rd_data,
  output reg        o_done,
  output reg        o_timeout,
  output reg        O_CE_N,
  output reg        O_CLE,
  output reg        O_ALE,
  output reg        O_WRITE_STROBE_N,
  output reg        O_OUTPUT_STROBE_N,
  output reg  [7:0] O_IO_OUT,
  output reg        O_IO_OE,
  input  wire [7:0] I_IO_IN,
  input  wire       I_READY_BUSY_N
);
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_WLOW  = 3'h1;
  localparam [2:0] ST_WHIGH = 3'h2;
  localparam [2:0] ST_RLOW  = 3'h3;
  localparam [2:0] ST_RHIGH = 3'h4;
  localparam [2:0] ST_BUSY  = 3'h5;
  localparam [2:0] ST_GAP   = 3'h6;

  localparam [3:0] CYC_LOW   = `NFH_CYC_LOW;
  localparam [3:0] CYC_HIGH  = `NFH_CYC_HIGH;
  localparam [3:0] CYC_HOLD  = `NFH_CYC_HOLD;
  localparam [3:0] CYC_AGAP  = `NFH_CYC_AGAP;
  localparam [3:0] CYC_RGAP  = `NFH_CYC_RGAP;
  // timeout limits, parameters so simulation can shorten them
  parameter [23:0] TO_FETCH   = `NFH_TO_FETCH;
  parameter [23:0] TO_CACHERD = `NFH_TO_CACHE_RD;
  parameter [23:0] TO_COPY    = `NFH_TO_COPY;
  parameter [23:0] TO_RESET   = `NFH_TO_RESET;
  parameter [23:0] TO_CPSHORT = `NFH_TO_CPROG_SHORT;
  parameter [23:0] TO_CPLONG  = `NFH_TO_CPROG_LONG;
  parameter [23:0] TO_PLAST   = `NFH_TO_PROG_LAST;

  reg  [2:0]  state;
  reg  [3:0]  tcnt;
  reg  [23:0] bcnt;
  reg  [23:0] limit;
  reg         last_addr;
  reg         rd_push;
  reg  [7:0]  rd_byte;
  wire        buf_ready;
  wire        take;

  // reads stall while the buffer is full, so no byte is lost
  assign o_op_ready = (state == ST_IDLE) &
                      ((i_op_kind != `NFH_OP_RDATA) | buf_ready);
  assign take = i_op_valid & o_op_ready;

  nfh_buf2 u_buf (
    .i_clk   (I_SYS_CLK),
    .i_rst   (I_SYS_RST),
    .i_valid (rd_push),
    .o_ready (buf_ready),
    .i_data  (rd_byte),
    .o_valid (o_rd_valid),
    .i_ready (i_rd_ready),
    .o_data  (o_rd_data)
  );

  always @* begin
    case (i_op_data[2:0])
      `NFH_WC_FETCH:       limit = TO_FETCH;
      `NFH_WC_CACHE_RD:    limit = TO_CACHERD;
      `NFH_WC_COPY:        limit = TO_COPY;
      `NFH_WC_RESET:       limit = TO_RESET;
      `NFH_WC_CPROG_SHORT: limit = TO_CPSHORT;
      `NFH_WC_CPROG_LONG:  limit = TO_CPLONG;
      `NFH_WC_PROG_LAST:   limit = TO_PLAST;
      default:             limit = TO_CPLONG;
    endcase
  end

  always @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state             <= ST_IDLE;
      tcnt              <= 4'h0;
      bcnt              <= 24'h000000;
      last_addr         <= 1'b0;
      rd_push           <= 1'b0;
      rd_byte           <= 8'h00;
      o_done            <= 1'b0;
      o_timeout         <= 1'b0;
      O_CE_N            <= 1'b1;
      O_CLE             <= 1'b0;
      O_ALE             <= 1'b0;
      O_WRITE_STROBE_N  <= 1'b1;
      O_OUTPUT_STROBE_N <= 1'b1;
      O_IO_OUT          <= 8'h00;
      O_IO_OE           <= 1'b0;
    end else begin
      rd_push <= 1'b0;
      o_done  <= 1'b0;
      case (state)
        ST_IDLE: begin
          tcnt <= 4'h0;
          if (take) begin
            O_CE_N <= 1'b0;
            case (i_op_kind)
              `NFH_OP_CMD, `NFH_OP_ADDR: begin
                O_CLE            <= (i_op_kind == `NFH_OP_CMD);
                O_ALE            <= (i_op_kind == `NFH_OP_ADDR);
                O_IO_OUT         <= i_op_data;
                O_IO_OE          <= 1'b1;
                O_WRITE_STROBE_N <= 1'b0;
                last_addr        <= (i_op_kind == `NFH_OP_ADDR);
                state            <= ST_WLOW;
              end
              `NFH_OP_WDATA: begin
                O_CLE    <= 1'b0;
                O_ALE    <= 1'b0;
                O_IO_OUT <= i_op_data;
                O_IO_OE  <= 1'b1;
                if (last_addr) begin
                  tcnt  <= CYC_AGAP;
                  state <= ST_GAP;
                end else begin
                  O_WRITE_STROBE_N <= 1'b0;
                  state            <= ST_WLOW;
                end
                last_addr <= 1'b0;
              end
              `NFH_OP_RDATA: begin
                O_CLE             <= 1'b0;
                O_ALE             <= 1'b0;
                O_IO_OE           <= 1'b0;
                O_OUTPUT_STROBE_N <= 1'b0;
                last_addr         <= 1'b0;
                state             <= ST_RLOW;
              end
              `NFH_OP_WAIT: begin
                O_CLE     <= 1'b0;
                O_ALE     <= 1'b0;
                O_IO_OE   <= 1'b0;
                bcnt      <= limit;
                o_timeout <= 1'b0;
                last_addr <= 1'b0;
                state     <= ST_BUSY;
              end
              default: begin
                o_done <= 1'b1;
              end
            endcase
          end
        end
        ST_WLOW: begin
          tcnt <= tcnt + 4'h1;
          if (tcnt + 4'h1 >= CYC_LOW) begin
            O_WRITE_STROBE_N <= 1'b1;
            tcnt             <= 4'h0;
            state            <= ST_WHIGH;
          end
        end
        ST_WHIGH: begin
          tcnt <= tcnt + 4'h1;
          if (tcnt + 4'h1 >= CYC_HIGH) begin
            O_CLE  <= 1'b0;
            O_ALE  <= 1'b0;
            o_done <= 1'b1;
            state  <= ST_IDLE;
          end
        end
        ST_RLOW: begin
          tcnt <= tcnt + 4'h1;
          if (tcnt + 4'h1 >= CYC_LOW) begin
            // sample at strobe end, past the 20 ns access time
            rd_byte           <= I_IO_IN;
            rd_push           <= 1'b1;
            O_OUTPUT_STROBE_N <= 1'b1;
            tcnt              <= 4'h0;
            state             <= ST_RHIGH;
          end
        end
        ST_RHIGH: begin
          tcnt <= tcnt + 4'h1;
          // long high time, device lets go
          if (tcnt + 4'h1 >= CYC_HOLD) begin
            o_done <= 1'b1;
            state  <= ST_IDLE;
          end
        end
        ST_BUSY: begin
          // busy low until ready or timeout
          if (bcnt != 24'h000000)
            bcnt <= bcnt - 24'h000001;
          if (tcnt < 4'h2) begin
            // skip the strobe-to-busy window before sampling
            tcnt <= tcnt + 4'h1;
          end else if (I_READY_BUSY_N) begin
            tcnt  <= CYC_RGAP;
            state <= ST_GAP;
          end else if (bcnt == 24'h000000) begin
            o_timeout <= 1'b1;
            o_done    <= 1'b1;
            state     <= ST_IDLE;
          end
        end
        ST_GAP: begin
          if (tcnt > 4'h1) begin
            tcnt <= tcnt - 4'h1;
          end else if (O_IO_OE & ~O_CLE & ~O_ALE) begin
            O_WRITE_STROBE_N <= 1'b0;
            tcnt             <= 4'h0;
            state            <= ST_WLOW;
          end else begin
            o_done <= 1'b1;
            state  <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

/* File: verification/nfh_host_properties.sv */
/*
  pin timing checker for the nand flash host sequencer.
  assumes binding to nfh_host, one clock domain.
*/
module nfh_host_chk (
  input wire I_SYS_CLK,
  input wire I_SYS_RST,
  input wire I_READY_BUSY_N,
  input wire O_CE_N,
  input wire O_CLE,
  input wire O_ALE,
  input wire O_WRITE_STROBE_N,
  input wire O_OUTPUT_STROBE_N,
  input wire O_IO_OE,
  input wire o_rd_valid,
  input wire o_timeout
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);
  logic [3:0] gap;
  // cycles since last address strobe rise, saturating
  always @(posedge I_SYS_CLK or posedge I_SYS_RST)
    if (I_SYS_RST) gap <= 4'hF;
    else if ($rose(O_WRITE_STROBE_N) && O_ALE) gap <= 4'h1;
    else if (gap != 4'hF) gap <= gap + 4'h1;
  property p_no_drive;
    !O_OUTPUT_STROBE_N |-> !O_IO_OE;
  endproperty
  a_no_drive: assert property (p_no_drive)
    else $error("host drives bus under read strobe");
  property p_ready_gap;
    $rose(I_READY_BUSY_N) |-> (O_WRITE_STROBE_N && O_OUTPUT_STROBE_N) [*3];
  endproperty
  a_ready_gap: assert property (p_ready_gap)
    else $error("strobe too soon after ready");
  property p_busy_idle;
    !I_READY_BUSY_N |-> O_WRITE_STROBE_N && O_OUTPUT_STROBE_N;
  endproperty
  a_busy_idle: assert property (p_busy_idle)
    else $error("strobe while device busy");
  property p_addr_gap;
    $fell(O_WRITE_STROBE_N) && !O_CLE && !O_ALE |-> gap >= 4'hA;
  endproperty
  a_addr_gap: assert property (p_addr_gap)
    else $error("data strobe too close to address");
  property p_tmo_busy;
    $rose(o_timeout) |-> !$past(I_READY_BUSY_N);
  endproperty
  a_tmo_busy: assert property (p_tmo_busy)
    else $error("timeout while device ready");
  property p_read_lands;
    $fell(O_OUTPUT_STROBE_N) |-> ##[3:5] o_rd_valid;
  endproperty
  a_read_lands: assert property (p_read_lands)
    else $error("read byte not delivered");
  property p_long_high;
    $rose(O_OUTPUT_STROBE_N) |-> O_OUTPUT_STROBE_N [*4];
  endproperty
  a_long_high: assert property (p_long_high)
    else $error("read strobe high interval short");
  property p_cmd_cycle;
    $fell(O_WRITE_STROBE_N) |-> (!O_CE_N && O_IO_OE && !O_WRITE_STROBE_N) [*3];
  endproperty
  a_cmd_cycle: assert property (p_cmd_cycle)
    else $error("write cycle malformed");
endmodule
bind nfh_host nfh_host_chk u_chk (.I_SYS_CLK, .I_SYS_RST, .I_READY_BUSY_N, .O_CE_N, .O_CLE,
  .O_ALE, .O_WRITE_STROBE_N, .O_OUTPUT_STROBE_N, .O_IO_OE, .o_rd_valid, .o_timeout);

/* File: verification/nfh_dev_model.sv */
/*
  behavioural flash device: busy timer, status byte, column counter.
  assumes pins synchronous to the host clock; no reset of its own.
*/
module nfh_dev_model #(
  parameter logic [7:0] STATUS = 8'hE0
) (
  input  logic        i_clk,
  input  logic        i_ce_n,
  input  logic        i_cle,
  input  logic        i_wstrb_n,
  input  logic        i_ostrb_n,
  input  logic        i_host_oe,
  input  logic [7:0]  i_host_out,
  input  logic [15:0] i_busy_cyc,
  output logic [7:0]  o_bus,
  output logic        o_ready_busy_n
);
  logic        wp = 1'b1;
  logic        rp = 1'b1;
  logic        stat = 1'b0;
  logic [2:0]  drv = 3'h0;
  logic [7:0]  col = 8'h00;
  logic [7:0]  last = 8'h00;
  logic [15:0] busy = 16'h0000;
  assign o_ready_busy_n = (busy == 16'h0000);
  // released bus shows inverted value, not a stale one
  assign o_bus = i_host_oe ? i_host_out : (drv != 3'h0) ? last : ~last;
  always @(posedge i_clk) begin
    wp <= i_wstrb_n;
    rp <= i_ostrb_n;
    if (busy != 16'h0000) busy <= busy - 16'h0001;
    if (!wp && i_wstrb_n && i_cle && !i_ce_n) begin
      stat <= (i_host_out == 8'h70);
      if (i_host_out == 8'h00) col <= 8'h00;
      case (i_host_out)
        8'h30, 8'h31, 8'h3F, 8'h3A, 8'h10, 8'h11, 8'h15, 8'hD0, 8'hFF: busy <= i_busy_cyc;
        default: ;
      endcase
    end
    if (rp && !i_ostrb_n) begin
      last <= stat ? STATUS : col;
      col <= stat ? col : col + 8'h01;
      drv <= 3'h7;
    end
    // hold past strobe rise, then release
    else if (!rp && i_ostrb_n) drv <= 3'h4;
    else if (drv != 3'h0 && drv != 3'h7) drv <= drv - 3'h1;
  end
endmodule

/* File: verification/tb_top.sv */
/*
  testbench for nfh_host against the behavioural flash model.
  assumes core/ on the include path.
*/
`include "nfh_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] STAT = 8'hE0;
  logic        clk = 0, rst = 1, op_valid = 0, rd_ready = 0;
  logic [2:0]  op_kind = 0;
  logic [7:0]  op_data = 0;
  logic [15:0] busy_cyc = 16'h0014;
  wire         op_ready, rd_valid, done, tmo, ce_n, cle, ale, ws_n, os_n, oe, rb_n;
  wire  [7:0]  rd_data, io_out, io_in;
  int          fail_count = 0, total_checks = 0;
  // reset limit shortened so the timeout case stays quick
  nfh_host #(.TO_RESET(24'd200)) dut (.I_SYS_CLK(clk), .I_SYS_RST(rst),
    .i_op_valid(op_valid), .o_op_ready(op_ready), .i_op_kind(op_kind), .i_op_data(op_data),
    .o_rd_valid(rd_valid), .i_rd_ready(rd_ready), .o_rd_data(rd_data), .o_done(done),
    .o_timeout(tmo), .O_CE_N(ce_n), .O_CLE(cle), .O_ALE(ale), .O_WRITE_STROBE_N(ws_n),
    .O_OUTPUT_STROBE_N(os_n), .O_IO_OUT(io_out), .O_IO_OE(oe), .I_IO_IN(io_in),
    .I_READY_BUSY_N(rb_n));
  nfh_dev_model #(.STATUS(STAT)) u_dev (.i_clk(clk), .i_ce_n(ce_n), .i_cle(cle),
    .i_wstrb_n(ws_n), .i_ostrb_n(os_n), .i_host_oe(oe), .i_host_out(io_out),
    .i_busy_cyc(busy_cyc), .o_bus(io_in), .o_ready_busy_n(rb_n));
  initial forever #4 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // entered and left at a falling edge
  task automatic op(input logic [2:0] k, input logic [7:0] d);
    int n;
    op_kind = k;
    op_data = d;
    op_valid = 1;
    n = 0;
    while (op_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    op_valid = 0;
    n = 0;
    while (done !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk({7'h0, done}, 8'h01);
  endtask
  task automatic pop(input logic [7:0] exp);
    chk({7'h0, rd_valid}, 8'h01);
    chk(rd_data, exp);
    rd_ready = 1;
    @(negedge clk);
    rd_ready = 0;
  endtask
  task automatic t_status;
    op(`NFH_OP_CMD, `NFH_CMD_STATUS);
    op(`NFH_OP_RDATA, 8'h00);
    pop(STAT);
    // undefined op kinds are only answered with done
    op(3'h5, 8'h00);
    $display("status test ended");
  endtask
  task automatic t_read;
    op(`NFH_OP_CMD, `NFH_CMD_READ1);
    repeat (5) op(`NFH_OP_ADDR, 8'h00);
    op(`NFH_OP_CMD, `NFH_CMD_READ2);
    op(`NFH_OP_WAIT, {5'h0, `NFH_WC_FETCH});
    chk({7'h0, tmo}, 8'h00);
    repeat (2) op(`NFH_OP_RDATA, 8'h00);
    // full buffer must refuse a third read
    op_kind = `NFH_OP_RDATA;
    op_valid = 1;
    repeat (3) begin
      @(negedge clk);
      chk({7'h0, op_ready}, 8'h00);
    end
    op_valid = 0;
    pop(8'h00);
    pop(8'h01);
    op(`NFH_OP_RDATA, 8'h00);
    pop(8'h02);
    $display("read test ended");
  endtask
  task automatic t_prog;
    logic [7:0] last_cmd [2] = '{`NFH_CMD_CACHE_PROG, `NFH_CMD_PROG2};
    logic [2:0] last_wc [2] = '{`NFH_WC_CPROG_LONG, `NFH_WC_PROG_LAST};
    for (int i = 0; i < 2; i++) begin
      op(`NFH_OP_CMD, `NFH_CMD_PROG1);
      repeat (5) op(`NFH_OP_ADDR, 8'h01);
      op(`NFH_OP_WDATA, 8'hA5);
      op(`NFH_OP_WDATA, 8'h5A);
      // bus value stands until the next op
      chk(io_out, 8'h5A);
      op(`NFH_OP_CMD, last_cmd[i]);
      op(`NFH_OP_WAIT, {5'h0, last_wc[i]});
      chk({7'h0, tmo}, 8'h00);
    end
    $display("program test ended");
  endtask
  task automatic t_cache;
    // last entry uses the undefined wait class, which falls back to the long limit
    logic [7:0] cmds [5] = '{8'h31, 8'h3F, 8'h3A, 8'h11, 8'h11};
    logic [2:0] cls [5] = '{3'h1, 3'h1, 3'h2, 3'h4, 3'h7};
    busy_cyc = 16'h0096;
    for (int i = 0; i < 5; i++) begin
      op(`NFH_OP_CMD, cmds[i]);
      op(`NFH_OP_WAIT, {5'h0, cls[i]});
      chk({7'h0, tmo}, 8'h00);
    end
    $display("cache test ended");
  endtask
  task automatic t_timeout;
    busy_cyc = 16'h0258;
    op(`NFH_OP_CMD, `NFH_CMD_RESET);
    op(`NFH_OP_WAIT, {5'h0, `NFH_WC_RESET});
    chk({7'h0, tmo}, 8'h01);
    $display("timeout test ended");
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    complete_run;
  end
  initial begin
    repeat (16) @(negedge clk);
    rst = 0;
    t_status;
    t_read;
    t_prog;
    t_cache;
    t_timeout;
    complete_run;
  end
endmodule
